/* common/ocdc_defs.svh */
`ifndef OCDC_DEFS_SVH
`define OCDC_DEFS_SVH

// ===========================================================
// register offsets (byte addresses on the register bus)
// ===========================================================
`define OCDC_OFF_OSC        12'h000
`define OCDC_OFF_DIV        12'h004
`define OCDC_OFF_FBD        12'h008
`define OCDC_OFF_TUN        12'h00C
`define OCDC_OFF_PDIV       12'h010

// ===========================================================
// oscillator control field positions
// ===========================================================
`define OCDC_OSC_SWREQ_BIT  0
`define OCDC_OSC_CFAIL_BIT  3

// ===========================================================
// unlock keys and key-tracker states
// ===========================================================
`define OCDC_KEY_HI_A       8'h78
`define OCDC_KEY_HI_B       8'h9A
`define OCDC_KEY_LO_A       8'h46
`define OCDC_KEY_LO_B       8'h57
`define OCDC_KEY_IDLE       2'h0
`define OCDC_KEY_HALF       2'h1
`define OCDC_KEY_OPEN       2'h2

// ===========================================================
// reset values
// ===========================================================
`define OCDC_RST_DOZE       3'h3
`define OCDC_RST_INTERNAL_RC_POSTSCALER     3'h0
`define OCDC_RST_PRE        4'h1
`define OCDC_RST_FB         8'h96
`define OCDC_RST_VCO        2'h0
`define OCDC_RST_POST1      3'h4
`define OCDC_RST_POST2      3'h1
`define OCDC_RST_TUNE       6'h00

// ===========================================================
// limits and scale figures
// ===========================================================
`define OCDC_PRE_MIN        4'h1
`define OCDC_PRE_MAX        4'h8
`define OCDC_TUN_STEP_PPM   16'h01D6
`define OCDC_STRAP_WAIT     2'h3

`endif

/* common/ocdc_pkg.sv */
package ocdc_pkg;

  // =========================================================
  // oscillator source codes
  // =========================================================
  typedef enum logic [2:0] {
    SRC_FRC     = 3'b000,
    SRC_INTERNAL_RC_WITH_PLL  = 3'b001,
    SRC_PRI     = 3'b010,
    SRC_PRIPLL  = 3'b011,
    SRC_RSVD    = 3'b100,
    SRC_LPRC    = 3'b101,
    SRC_BFRC    = 3'b110,
    SRC_FRCDIVN = 3'b111
  } ocdc_src_e;

  // switch sequencer states
  typedef enum logic [1:0] {
    SW_IDLE    = 2'b00,
    SW_REQ     = 2'b01,
    SW_RELEASE = 2'b10
  } ocdc_sw_e;

  // =========================================================
  // bus carriers
  // =========================================================
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } ocdc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ocdc_apb_rsp_s;

  // decoded clock settings handed to the clock tree
  typedef struct packed {
    ocdc_src_e          cur_source;
    logic [8:0]         frc_div;
    logic [3:0]         pll_pre_div;
    logic [7:0]         pll_fb;
    logic [2:0]         vco_div;
    logic [5:0]         post_prod;
    logic signed [15:0] tune_ppm;
  } ocdc_cfg_s;

  // =========================================================
  // module state records
  // =========================================================
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] q;
  } ocdc_sync_s;

  typedef struct packed {
    logic [6:0] cnt;
    logic       pulse;
  } ocdc_doze_s;

  typedef struct packed {
    ocdc_src_e   osc_cur;
    ocdc_src_e   osc_new;
    logic        swreq;
    logic        cfail;
    logic        trap;
    ocdc_sw_e    sw_st;
    logic [1:0]  hi_key;
    logic [1:0]  lo_key;
    logic        strap_done;
    logic [1:0]  boot_cnt;
    logic        recover_on_interrupt;
    logic [2:0]  doze;
    logic        doze_en;
    logic [2:0]  frc_post;
    logic [3:0]  pll_pre;
    logic [7:0]  pll_fb;
    logic [5:0]  tune;
    logic [1:0]  vco;
    logic [2:0]  post1;
    logic [2:0]  post2;
    logic [31:0] prdata;
    logic        pslverr;
    ocdc_cfg_s   cfg;
  } ocdc_state_s;

endpackage : ocdc_pkg

/* logic/ocdc_sync.sv */
`timescale 1ns/1ps

// ===========================================================
// three-stage pin synchroniser with agreement filter
// ===========================================================
module ocdc_sync (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [5:0] pin_in,
  output logic      [5:0] pin_q
);

  ocdc_pkg::ocdc_sync_s sy_r;   // all stages
  ocdc_pkg::ocdc_sync_s sy_nxt; // next stages
  logic [5:0]           q_nxt;  // filtered level per bit

  // per-bit agreement: change taken once s2 and s3 agree
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_bit
      assign q_nxt[gi] = (sy_r.s2[gi] == sy_r.s3[gi]) ? sy_r.s3[gi]
                                                       : sy_r.q[gi];
    end
  endgenerate

  // stage shift; s1 only feeds s2
  always_comb begin
    sy_nxt    = sy_r;
    sy_nxt.s1 = pin_in;
    sy_nxt.s2 = sy_r.s1;
    sy_nxt.s3 = sy_r.s2;
    sy_nxt.q  = q_nxt;
  end

  // stage registers, one process keeps a single driver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy_r <= '0;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign pin_q = sy_r.q;

endmodule : ocdc_sync

/* logic/ocdc_doze.sv */
`timescale 1ns/1ps

// ===========================================================
// processor clock-reduction enable divider
// ===========================================================
module ocdc_doze (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       doze_en,
  input  wire logic [2:0] doze_ratio,
  output logic            cpu_clk_en
);

  ocdc_pkg::ocdc_doze_s dz_r;   // counter and pulse
  ocdc_pkg::ocdc_doze_s dz_nxt; // next value
  logic [6:0]           lim;    // last count of one period

  // divide by two to the code, only while enabled
  always_comb begin
    dz_nxt = dz_r;
    lim    = doze_en ? 7'((8'h01 << doze_ratio) - 8'h01) : 7'h00;
    if (dz_r.cnt >= lim) begin
      // wrap; >= also recovers at once when ratio drops
      dz_nxt.cnt   = 7'h00;
      dz_nxt.pulse = 1'b1;
    end else begin
      dz_nxt.cnt   = dz_r.cnt + 7'h01;
      dz_nxt.pulse = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dz_r <= '0;
    end else begin
      dz_r <= dz_nxt;
    end
  end

  assign cpu_clk_en = dz_r.pulse;

endmodule : ocdc_doze

/* logic/ocdc_top.sv */
`timescale 1ns/1ps
`include "ocdc_defs.svh"

// Overview of operation
// - monitor failure sets clock fail flag
// - software one on flag acts as failure
// - switch bit starts switch, self-clears
// - oscillator control writes need unlock
// - three-bit source codes, reserved as rc
// - interrupt with recover clears reduction
// - reduction ratio two to code, reset 011
// - disabled reduction forces ratio one
// - ratio writes ignored while enabled
// - enable ignored while ratio is 000
// - prescaler 1..8, reset 0001
// - prescaler writable while pll runs
// - signed rc tuning code, 0.047% steps
// - vco divider 4,3,2,1 for 00..11
// - post dividers reset to 4 and 1
// - unimplemented bits read zero

module ocdc_top (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire ocdc_pkg::ocdc_apb_req_s apb_req,
  output ocdc_pkg::ocdc_apb_rsp_s      apb_rsp,
  input  wire logic                    fail_safe_clock_monitor_fail_pin,
  input  wire logic                    switch_done_pin,
  input  wire logic                    pll_lock_pin,
  input  wire logic [2:0]              src_strap_pin,
  input  wire logic                    irq_event,
  output ocdc_pkg::ocdc_cfg_s          clk_cfg,
  output logic                         cpu_clk_en,
  output logic                         osc_switch_req,
  output logic [2:0]                   osc_switch_target,
  output logic                         osc_fail_trap
);

  // =========================================================
  // declarations
  // =========================================================
  ocdc_pkg::ocdc_state_s st_r;      // all block state
  ocdc_pkg::ocdc_state_s st_nxt;    // next state
  logic [5:0]            pin_q;     // filtered pin levels
  logic                  fail_q;    // monitor failure level
  logic                  done_q;    // switch finished level
  logic                  lock_q;    // pll lock level
  logic [2:0]            strap_q;   // power-on source strap
  logic                  wr;        // write access phase
  logic                  setup;     // setup phase
  logic                  hi_wr;     // osc high byte written
  logic                  lo_wr;     // osc low byte written
  logic [7:0]            hi_b;      // written high byte
  logic [7:0]            lo_b;      // written low byte
  logic                  cf_set;    // flag set causes
  logic                  cf_clr;    // software clear
  logic [2:0]            ratio_w;   // ratio after write

  // =========================================================
  // pin synchroniser and reduction divider
  // =========================================================
  ocdc_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  ({src_strap_pin, pll_lock_pin, switch_done_pin,
               fail_safe_clock_monitor_fail_pin}),
    .pin_q   (pin_q)
  );

  assign fail_q  = pin_q[0];
  assign done_q  = pin_q[1];
  assign lock_q  = pin_q[2];
  assign strap_q = pin_q[5:3];

  ocdc_doze u_doze (
    .pclk       (pclk),
    .presetn    (presetn),
    .doze_en    (st_r.doze_en),
    .doze_ratio (st_r.doze),
    .cpu_clk_en (cpu_clk_en)
  );

  // =========================================================
  // next-state logic
  // =========================================================
  always_comb begin
    st_nxt  = st_r;
    wr      = apb_req.psel & apb_req.penable & apb_req.pwrite;
    setup   = apb_req.psel & ~apb_req.penable;
    hi_b    = apb_req.pwdata[15:8];
    lo_b    = apb_req.pwdata[7:0];
    hi_wr   = wr & apb_req.pstrb[1]
              & (apb_req.paddr == `OCDC_OFF_OSC);
    lo_wr   = wr & apb_req.pstrb[0]
              & (apb_req.paddr == `OCDC_OFF_OSC);
    cf_clr  = 1'b0;
    cf_set  = fail_q;
    ratio_w = st_r.doze;

    // straps captured when boot_cnt reaches OCDC_STRAP_WAIT, one cycle before the filtered level appears
    if (!st_r.strap_done) begin
      if (st_r.boot_cnt == `OCDC_STRAP_WAIT) begin
        st_nxt.osc_cur    = ocdc_pkg::ocdc_src_e'(strap_q);
        st_nxt.osc_new    = ocdc_pkg::ocdc_src_e'(strap_q);
        st_nxt.strap_done = 1'b1;
      end else begin
        st_nxt.boot_cnt = st_r.boot_cnt + 2'h1;
      end
    end

    // switch sequencer; runs before writes so a set wins
    case (st_r.sw_st)
      ocdc_pkg::SW_IDLE: begin
        if (st_r.swreq) begin
          st_nxt.sw_st = ocdc_pkg::SW_REQ;
        end
      end
      ocdc_pkg::SW_REQ: begin
        if (done_q) begin
          st_nxt.osc_cur = st_r.osc_new;
          st_nxt.swreq   = 1'b0;
          st_nxt.sw_st   = ocdc_pkg::SW_RELEASE;
        end
      end
      ocdc_pkg::SW_RELEASE: begin
        // wait for the clock tree to drop its done level
        if (!done_q) begin
          st_nxt.sw_st = ocdc_pkg::SW_IDLE;
        end
      end
      default: begin
        st_nxt.sw_st = ocdc_pkg::SW_IDLE;
      end
    endcase

    // key trackers: any write that does not advance resets
    if (wr) begin
      st_nxt.hi_key = `OCDC_KEY_IDLE;
      st_nxt.lo_key = `OCDC_KEY_IDLE;
    end
    if (hi_wr) begin
      if (st_r.hi_key == `OCDC_KEY_OPEN) begin
        st_nxt.osc_new = ocdc_pkg::ocdc_src_e'(hi_b[2:0]);
      end else if (st_r.hi_key == `OCDC_KEY_HALF
                   && hi_b == `OCDC_KEY_HI_B) begin
        st_nxt.hi_key = `OCDC_KEY_OPEN;
      end else if (hi_b == `OCDC_KEY_HI_A) begin
        st_nxt.hi_key = `OCDC_KEY_HALF;
      end
    end
    if (lo_wr) begin
      if (st_r.lo_key == `OCDC_KEY_OPEN) begin
        cf_clr = ~lo_b[`OCDC_OSC_CFAIL_BIT];
        cf_set = fail_q | lo_b[`OCDC_OSC_CFAIL_BIT];
        if (lo_b[`OCDC_OSC_SWREQ_BIT]) begin
          st_nxt.swreq = 1'b1;
        end
      end else if (st_r.lo_key == `OCDC_KEY_HALF
                   && lo_b == `OCDC_KEY_LO_B) begin
        st_nxt.lo_key = `OCDC_KEY_OPEN;
      end else if (lo_b == `OCDC_KEY_LO_A) begin
        st_nxt.lo_key = `OCDC_KEY_HALF;
      end
    end

    st_nxt.cfail = cf_set | (st_r.cfail & ~cf_clr);
    // trap on each rise of the flag
    st_nxt.trap  = cf_set & ~st_r.cfail;

    // clock divider register
    if (wr && apb_req.paddr == `OCDC_OFF_DIV) begin
      if (apb_req.pstrb[1]) begin
        st_nxt.recover_on_interrupt      = apb_req.pwdata[15];
        if (!st_r.doze_en) begin
          ratio_w = apb_req.pwdata[14:12];
        end
        st_nxt.doze     = ratio_w;
        st_nxt.doze_en  = apb_req.pwdata[11] & (ratio_w != 3'h0);
        st_nxt.frc_post = apb_req.pwdata[10:8];
      end
      // prescaler open at all times; reserved codes dropped
      if (apb_req.pstrb[0]
          && apb_req.pwdata[3:0] >= `OCDC_PRE_MIN
          && apb_req.pwdata[3:0] <= `OCDC_PRE_MAX) begin
        st_nxt.pll_pre = apb_req.pwdata[3:0];
      end
    end
    if (wr && apb_req.pstrb[0]
        && apb_req.paddr == `OCDC_OFF_FBD) begin
      st_nxt.pll_fb = apb_req.pwdata[7:0];
    end
    if (wr && apb_req.pstrb[0]
        && apb_req.paddr == `OCDC_OFF_TUN) begin
      st_nxt.tune = apb_req.pwdata[5:0];
    end
    if (wr && apb_req.paddr == `OCDC_OFF_PDIV) begin
      if (apb_req.pstrb[1]) begin
        st_nxt.vco = apb_req.pwdata[9:8];
      end
      if (apb_req.pstrb[0]) begin
        st_nxt.post1 = apb_req.pwdata[6:4];
        st_nxt.post2 = apb_req.pwdata[2:0];
      end
    end

    if (st_r.recover_on_interrupt && irq_event) begin
      st_nxt.doze_en = 1'b0;
    end

    // read data captured in setup so access needs no wait
    if (setup) begin
      st_nxt.pslverr = 1'b0;
      case (apb_req.paddr)
        `OCDC_OFF_OSC: begin
          st_nxt.prdata = {16'h0000, 1'b0, st_r.osc_cur, 1'b0,
                           st_r.osc_new, 2'b00, lock_q, 1'b0,
                           st_r.cfail, 2'b00, st_r.swreq};
        end
        `OCDC_OFF_DIV: begin
          st_nxt.prdata = {16'h0000, st_r.recover_on_interrupt, st_r.doze,
                           st_r.doze_en, st_r.frc_post, 4'h0,
                           st_r.pll_pre};
        end
        `OCDC_OFF_FBD: begin
          st_nxt.prdata = {24'h00_0000, st_r.pll_fb};
        end
        `OCDC_OFF_TUN: begin
          st_nxt.prdata = {26'h000_0000, st_r.tune};
        end
        `OCDC_OFF_PDIV: begin
          st_nxt.prdata = {22'h00_0000, st_r.vco, 1'b0,
                           st_r.post1, 1'b0, st_r.post2};
        end
        default: begin
          // unmapped: zero data and an error answer
          st_nxt.prdata  = 32'h0000_0000;
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end

    // decoded settings, one cycle behind the fields
    // reserved code runs as plain rc
    st_nxt.cfg.cur_source = (st_r.osc_cur == ocdc_pkg::SRC_RSVD)
                            ? ocdc_pkg::SRC_FRC : st_r.osc_cur;
    st_nxt.cfg.frc_div = (st_r.frc_post == 3'h7) ? 9'h100
                         : 9'(9'h001 << st_r.frc_post);
    st_nxt.cfg.pll_pre_div = st_r.pll_pre;
    st_nxt.cfg.pll_fb      = st_r.pll_fb;
    st_nxt.cfg.vco_div     = 3'h4 - {1'b0, st_r.vco};
    st_nxt.cfg.post_prod   = {3'h0, st_r.post1} * {3'h0, st_r.post2};
    st_nxt.cfg.tune_ppm    = {{10{st_r.tune[5]}}, st_r.tune}
                             * `OCDC_TUN_STEP_PPM;
  end

  // =========================================================
  // state register
  // =========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r          <= '0;
      st_r.osc_cur  <= ocdc_pkg::SRC_FRC;
      st_r.osc_new  <= ocdc_pkg::SRC_FRC;
      st_r.sw_st    <= ocdc_pkg::SW_IDLE;
      st_r.doze     <= `OCDC_RST_DOZE;
      st_r.frc_post <= `OCDC_RST_INTERNAL_RC_POSTSCALER;
      st_r.pll_pre  <= `OCDC_RST_PRE;
      st_r.pll_fb   <= `OCDC_RST_FB;
      st_r.tune     <= `OCDC_RST_TUNE;
      st_r.vco      <= `OCDC_RST_VCO;
      st_r.post1    <= `OCDC_RST_POST1;
      st_r.post2    <= `OCDC_RST_POST2;
    end else begin
      st_r <= st_nxt;
    end
  end

  // =========================================================
  // outputs
  // =========================================================
  assign apb_rsp.prdata    = st_r.prdata;
  assign apb_rsp.pready    = 1'b1;
  assign apb_rsp.pslverr   = st_r.pslverr & apb_req.psel
                             & apb_req.penable;
  assign clk_cfg           = st_r.cfg;
  assign osc_switch_req    = (st_r.sw_st == ocdc_pkg::SW_REQ);
  assign osc_switch_target = st_r.osc_new;
  assign osc_fail_trap     = st_r.trap;

endmodule : ocdc_top

/* testbench/ocdc_props.sv */
`timescale 1ns/1ps

// ==========================================================
// port checker for the clock control block
// ==========================================================
module ocdc_props (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire ocdc_pkg::ocdc_apb_req_s apb_req,
  input wire ocdc_pkg::ocdc_apb_rsp_s apb_rsp,
  input wire logic                    switch_done_pin,
  input wire ocdc_pkg::ocdc_cfg_s     clk_cfg,
  input wire logic                    cpu_clk_en,
  input wire logic                    osc_switch_req,
  input wire logic                    osc_fail_trap
);
  logic [7:0] gap_r;  // cycles since last cpu enable pulse
  logic [1:0] up_r;   // edges since reset release, saturates
  logic       acc;    // apb access phase
  logic       hit;    // mapped word address

  assign acc = apb_req.psel & apb_req.penable;
  assign hit = apb_req.paddr inside {12'h000, 12'h004, 12'h008,
                                     12'h00C, 12'h010};

  // gap counter, so long waits stay off long repetitions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r <= 8'h00;
      up_r  <= 2'h0;
    end else begin
      gap_r <= cpu_clk_en ? 8'h00 : gap_r + 8'h01;
      up_r  <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ========================================================
  // assertions
  // ========================================================
  a_ready_high: assert property (apb_rsp.pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |->
    apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && hit |-> !apb_rsp.pslverr)
    else $error("mapped access refused");
  a_trap_pulse: assert property (osc_fail_trap |=> !osc_fail_trap)
    else $error("trap longer than one cycle");
  a_done_drops: assert property (osc_switch_req && switch_done_pin
    |-> ##[1:6] !osc_switch_req)
    else $error("switch request not dropped");
  a_req_holds: assert property (
    (osc_switch_req && !switch_done_pin) [*5] |=> osc_switch_req)
    else $error("switch request dropped early");
  a_cpu_gap: assert property (gap_r <= 8'd128)
    else $error("cpu enable gap too long");
  a_pre_range: assert property (up_r == 2'h3 |->
    clk_cfg.pll_pre_div inside {[4'h1:4'h8]})
    else $error("prescaler holds reserved code");
  a_frc_pow: assert property (up_r == 2'h3 |->
    $onehot(clk_cfg.frc_div) && !clk_cfg.frc_div[7])
    else $error("postscaler not a legal power of two");
  a_vco_range: assert property (up_r == 2'h3 |->
    clk_cfg.vco_div inside {[3'h1:3'h4]})
    else $error("vco divider out of range");
  a_src_code: assert property (
    clk_cfg.cur_source != ocdc_pkg::SRC_RSVD)
    else $error("reserved source shown");

  c_switch: cover property ($fell(osc_switch_req));
  c_trap: cover property (osc_fail_trap);
  c_slverr: cover property (acc && apb_rsp.pslverr);
endmodule : ocdc_props

bind ocdc_top ocdc_props u_props (
  .pclk            (pclk),
  .presetn         (presetn),
  .apb_req         (apb_req),
  .apb_rsp         (apb_rsp),
  .switch_done_pin (switch_done_pin),
  .clk_cfg         (clk_cfg),
  .cpu_clk_en      (cpu_clk_en),
  .osc_switch_req  (osc_switch_req),
  .osc_fail_trap   (osc_fail_trap)
);

/* testbench/osc_pll_clock_divider_control_tb.sv */
`timescale 1ns/1ps
`include "ocdc_defs.svh"

// ==========================================================
// register-level bench for the clock control block
// ==========================================================
module osc_pll_clock_divider_control_tb;
  logic                    pclk;
  logic                    presetn;
  ocdc_pkg::ocdc_apb_req_s apb_req;
  ocdc_pkg::ocdc_apb_rsp_s apb_rsp;
  logic                    fail_safe_clock_monitor_fail_pin;
  logic                    switch_done_pin;
  logic                    pll_lock_pin;
  logic                    irq_event;
  ocdc_pkg::ocdc_cfg_s     clk_cfg;
  logic                    cpu_clk_en;
  logic                    osc_switch_req;
  logic [2:0]              osc_switch_target;
  logic                    osc_fail_trap;
  logic [31:0]             rd_q;   // last read word
  int                      num_errors;
  int                      tests_run;
  int                      i;

  // strap tied low: boot source stays internal rc
  ocdc_top dut (
    .pclk(pclk), .presetn(presetn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .fail_safe_clock_monitor_fail_pin(fail_safe_clock_monitor_fail_pin),
    .switch_done_pin(switch_done_pin), .pll_lock_pin(pll_lock_pin),
    .src_strap_pin(3'h0), .irq_event(irq_event), .clk_cfg(clk_cfg),
    .cpu_clk_en(cpu_clk_en), .osc_switch_req(osc_switch_req),
    .osc_switch_target(osc_switch_target),
    .osc_fail_trap(osc_fail_trap)
  );

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  // ========================================================
  // tasks
  // ========================================================
  task automatic test_done;
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [15:0] d, input logic [3:0] s);
    int n;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, {16'h0000, d}, s};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    rd_q = apb_rsp.prdata;
    chk("pslverr", a > 12'h010, apb_rsp.pslverr);
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    if (apb_rsp.pready !== 1'b1) begin
      num_errors++;
      test_done();
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'h3);
  endtask : wr

  task automatic rd(input string nm, input logic [11:0] a,
                    input logic [15:0] e);
    apb(1'b0, a, 16'h0000, 4'h0);
    chk(nm, {16'h0000, e}, rd_q);
  endtask : rd

  // key pairs open one byte lane for the next write only
  task automatic key(input logic hi);
    apb(1'b1, 12'h000, hi ? 16'h7800 : 16'h0046, hi ? 4'h2 : 4'h1);
    apb(1'b1, 12'h000, hi ? 16'h9A00 : 16'h0057, hi ? 4'h2 : 4'h1);
  endtask : key

  // bounded poll; a spent bound ends the run
  task automatic wait_for(ref logic s, input logic v, input string nm);
    int n;
    n = 0;
    while (s !== v && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk(nm, {31'h0, v}, {31'h0, s});
    if (s !== v) test_done();
  endtask : wait_for

  // spacing of cpu enable pulses in cycles
  task automatic gap_chk(input int e);
    int n;
    // let the pulse left from the old ratio pass first
    repeat (2) @(posedge pclk);
    wait_for(cpu_clk_en, 1'b1, "cpu_clk_en");
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (cpu_clk_en !== 1'b1 && n < 300);
    chk("cpu gap", e, n);
  endtask : gap_chk

  task automatic irq;
    @(posedge pclk);
    irq_event <= 1'b1;
    @(posedge pclk);
    irq_event <= 1'b0;
  endtask : irq

  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    test_done();
  end

  // ========================================================
  // main sequence
  // ========================================================
  initial begin
    num_errors = 0;
    tests_run = 0;
    apb_req = '0;
    fail_safe_clock_monitor_fail_pin = 1'b0;
    switch_done_pin = 1'b0;
    pll_lock_pin = 1'b1;
    irq_event = 1'b0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd("osc", 12'h000, 16'h0020);
    rd("div", 12'h004, 16'h3001);
    rd("fbd", 12'h008, 16'h0096);
    rd("tun", 12'h00C, 16'h0000);
    rd("pdiv", 12'h010, 16'h0041);
    rd("unmapped", 12'h014, 16'h0000);
    chk("post_prod", 4, clk_cfg.post_prod);
    chk("pll_fb", 150, clk_cfg.pll_fb);
    wr(12'h000, 16'hFFFF);
    rd("osc nokey", 12'h000, 16'h0020);
    apb(1'b1, 12'h000, 16'h7800, 4'h2);
    wr(12'h008, 16'h0096);
    apb(1'b1, 12'h000, 16'h9A00, 4'h2);
    apb(1'b1, 12'h000, 16'h0500, 4'h2);
    rd("osc broken key", 12'h000, 16'h0020);
    key(1'b1);
    apb(1'b1, 12'h000, 16'h0300, 4'h2);
    rd("osc new", 12'h000, 16'h0320);
    key(1'b0);
    apb(1'b1, 12'h000, 16'h0001, 4'h1);
    wait_for(osc_switch_req, 1'b1, "switch req");
    chk("target", 3'h3, osc_switch_target);
    // request must stand while done is still low
    repeat (6) @(posedge pclk);
    switch_done_pin <= 1'b1;
    wait_for(osc_switch_req, 1'b0, "switch end");
    rd("osc cur", 12'h000, 16'h3320);
    chk("cur_source", 3'h3, clk_cfg.cur_source);
    switch_done_pin <= 1'b0;
    fail_safe_clock_monitor_fail_pin <= 1'b1;
    wait_for(osc_fail_trap, 1'b1, "fail trap");
    fail_safe_clock_monitor_fail_pin <= 1'b0;
    repeat (8) @(posedge pclk);
    rd("osc fail", 12'h000, 16'h3328);
    key(1'b0);
    apb(1'b1, 12'h000, 16'h0000, 4'h1);
    rd("osc clr", 12'h000, 16'h3320);
    key(1'b0);
    apb(1'b1, 12'h000, 16'h0008, 4'h1);
    wait_for(osc_fail_trap, 1'b1, "sw trap");
    rd("osc sw fail", 12'h000, 16'h3328);
    wr(12'h004, 16'h0801);
    rd("div zero en", 12'h004, 16'h0001);
    wr(12'h004, 16'h3801);
    gap_chk(8);
    wr(12'h004, 16'h5801);
    rd("div locked", 12'h004, 16'h3801);
    irq();
    rd("div no roi", 12'h004, 16'h3801);
    wr(12'h004, 16'hB801);
    irq();
    rd("div roi", 12'h004, 16'hB001);
    gap_chk(1);
    wr(12'h004, 16'h3000);
    wr(12'h004, 16'h3009);
    rd("pre rsvd", 12'h004, 16'h3001);
    wr(12'h004, 16'h30F8);
    rd("pre 8", 12'h004, 16'h3008);
    chk("pre_div", 4'h8, clk_cfg.pll_pre_div);
    for (i = 0; i < 8; i++) begin
      wr(12'h004, 16'h3001 | (16'(i) << 8));
      repeat (2) @(posedge pclk);
      chk("frc_div", (i == 7) ? 256 : (1 << i), clk_cfg.frc_div);
    end
    wr(12'h008, 16'hFFFF);
    rd("fbd", 12'h008, 16'h00FF);
    wr(12'h00C, 16'h0020);
    repeat (2) @(posedge pclk);
    chk("tune", 32'h0000_C540, $unsigned(clk_cfg.tune_ppm));
    wr(12'h00C, 16'hFFFF);
    rd("tun", 12'h00C, 16'h003F);
    // pll reported stopped before post divider writes
    pll_lock_pin <= 1'b0;
    for (i = 0; i < 4; i++) begin
      wr(12'h010, (16'(i) << 8) | 16'h0021);
      repeat (2) @(posedge pclk);
      chk("vco_div", 4 - i, clk_cfg.vco_div);
    end
    chk("post_prod", 2, clk_cfg.post_prod);
    wr(12'h010, 16'hFFFF);
    rd("pdiv", 12'h010, 16'h0377);
    chk("post_prod", 49, clk_cfg.post_prod);
    rd("osc lock", 12'h000, 16'h3308);
    test_done();
  end
endmodule : osc_pll_clock_divider_control_tb
